// ===== pkg/uart_fc_cfg.svh
`ifndef UART_FC_CFG_SVH
`define UART_FC_CFG_SVH

`define IDX_DIV_LOW 6'h08
`define IDX_DIV_HIGH 6'h09
`define IDX_FEATURE 6'h0a
`define IDX_RESUME_ONE 6'h0b
`define IDX_RESUME_TWO 6'h0c
`define IDX_STOP_ONE 6'h0d
`define IDX_STOP_TWO 6'h0e
`define IDX_ADV_STATUS 6'h0f
`define IDX_LOWER_THR 6'h12
`define IDX_UPPER_THR 6'h13
`define IDX_IRQ_STATUS 6'h18
`define IDX_IRQ_MASK 6'h19

`define RXFC_LSB 0
`define TXFC_LSB 2
`define ENH_BIT 4
`define SPEC_BIT 5
`define ARTS_BIT 6
`define ACTS_BIT 7

`define ST_HALTED 0
`define ST_STOP_SENT 1
`define ST_FLOW_DET 2
`define ST_SPEC_DET 3

`define IRQ_FLOW 0
`define IRQ_SPEC 1

`define RST_BYTE 8'h00
`define RST_DIVISOR 16'h0000

`define SEL_OFF 2'h0
`define SEL_PAIR_TWO 2'h1
`define SEL_PAIR_ONE 2'h2
`define SEL_EITHER 2'h3

`endif

// ===== pkg/uart_fc_pkg.sv
package uart_fc_pkg;
  typedef logic [1:0] flow_sel_type;
  typedef logic [7:0] char_type;
  typedef enum {INS_IDLE, INS_STOP, INS_RESUME} ins_state_type;
endpackage

// ===== logic/char_match.sv
`timescale 1ns/10ps
`include "uart_fc_cfg.svh"
module char_match (
  input wire uart_fc_pkg::flow_sel_type rx_sel,
  input wire uart_fc_pkg::flow_sel_type tx_sel,
  input wire uart_fc_pkg::char_type resume_one,
  input wire uart_fc_pkg::char_type resume_two,
  input wire uart_fc_pkg::char_type stop_one,
  input wire uart_fc_pkg::char_type stop_two,
  input wire uart_fc_pkg::char_type rx_char,
  output logic stop_hit,
  output logic resume_hit,
  output logic spec_hit
);
  import uart_fc_pkg::*;
  logic s1, s2, r1, r2;

  assign s1 = (rx_char == stop_one);
  assign s2 = (rx_char == stop_two);
  assign r1 = (rx_char == resume_one);
  assign r2 = (rx_char == resume_two);

  always_comb begin
    stop_hit = 1'b0;
    resume_hit = 1'b0;
    spec_hit = s1 | s2;
    unique case (rx_sel)
      `SEL_OFF: begin
        stop_hit = 1'b0;
      end
      `SEL_PAIR_TWO: begin
        stop_hit = s2;
        resume_hit = r2;
      end
      `SEL_PAIR_ONE: begin
        stop_hit = s1;
        resume_hit = r1;
      end
      `SEL_EITHER: begin
        // Either pair only with transmit field one of the pair codes
        if (tx_sel == `SEL_PAIR_TWO || tx_sel == `SEL_PAIR_ONE) begin
          stop_hit = s1 | s2;
          resume_hit = r1 | r2;
        end
      end
    endcase
  end
endmodule

// ===== logic/flow_ctrl_core.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`include "uart_fc_cfg.svh"
// Function
// - Divisor low byte register, read-write, zero after reset.
// - Divisor high byte register, read-write, zero after reset.
// - Matching received stop character halts transmit after current character.
// - Matching received resume character restarts a halted transmitter.
// - Receive field: 00 off, 01 second pair, 10 first pair.
// - Receive field 11 accepts either pair if transmit field is 01/10.
// - Insert stop above upper level, resume below lower level.
// - Transmit field: 00 off, 01 second pair, 10 first; 11 reserved.
// - Enhanced bit gates all extended functions; clear means legacy UART.
// - Special detection compares received chars with both stop chars, interrupts.
// - Auto RTS drives rts_n high once fill level reaches upper threshold.
// - Auto RTS releases rts_n low when fill drops below lower threshold.
// - Auto CTS: no new character starts while cts_n is high.
// - Upper and lower thresholds come from two 8-bit level registers.
// - Received resume/stop sets read-clear detect flag, optionally interrupting.
module flow_ctrl_core #(
  parameter int ADDR_W = 8,
  parameter int LEVEL_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire uart_fc_pkg::char_type rx_char,
  input wire logic [LEVEL_W-1:0] rx_fifo_fill_level,
  input wire logic tx_busy,
  input wire logic ins_ready,
  output logic ins_valid,
  output uart_fc_pkg::char_type ins_char,
  output logic tx_allow,
  output logic [15:0] divisor,
  output logic bit_tick,
  input wire logic cts_n,
  output logic rts_n,
  output logic irq
);
  import uart_fc_pkg::*;

  char_type div_low_q, div_high_q, feature_q;
  char_type resume_one_q, resume_two_q, stop_one_q, stop_two_q;
  char_type lower_thr_q, upper_thr_q;
  logic [1:0] irq_sts_q, irq_mask_q;
  logic flow_det_q, spec_det_q;
  logic halted_q, halt_pend_q, stop_sent_q;
  logic cts_n_s1_q, cts_n_s2_q;
  logic rts_hold_q;
  logic [15:0] tick_cnt_q;
  ins_state_type ins_state_q;
  char_type ins_char_q;
  logic ins_valid_q, tx_allow_q, rts_n_q, irq_q, bit_tick_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;

  logic [5:0] idx;
  logic setup, access_wr, access_rd;
  logic enh, rx_fc_on, tx_fc_on, spec_on, auto_rts, auto_cts;
  flow_sel_type rx_sel, tx_sel;
  logic stop_hit, resume_hit, spec_hit;
  logic stop_ev, resume_ev, spec_ev;
  logic [LEVEL_W-1:0] upper_lvl, lower_lvl;
  logic above_upper, below_lower, at_upper;
  char_type tx_stop_char, tx_resume_char;
  logic status_rd, irq_sts_wr;
  logic [31:0] rd_word;
  logic rd_hit;

  assign idx = paddr[7:2];
  assign setup = psel & ~penable;
  assign access_wr = psel & penable & pready_q & pwrite;
  assign access_rd = psel & penable & pready_q & ~pwrite;

  // Extended functions only in enhanced mode
  assign enh = feature_q[`ENH_BIT];
  assign rx_sel = enh ? feature_q[`RXFC_LSB+:2] : `SEL_OFF;
  assign tx_sel = enh ? feature_q[`TXFC_LSB+:2] : `SEL_OFF;
  assign rx_fc_on = (rx_sel != `SEL_OFF);
  // Reserved 11 treated as off so nothing is inserted
  assign tx_fc_on = (tx_sel == `SEL_PAIR_ONE) ||
                    (tx_sel == `SEL_PAIR_TWO);
  assign spec_on = enh & feature_q[`SPEC_BIT];
  assign auto_rts = enh & feature_q[`ARTS_BIT];
  assign auto_cts = enh & feature_q[`ACTS_BIT];

  char_match matcher (
    .rx_sel(rx_sel),
    .tx_sel(tx_sel),
    .resume_one(resume_one_q),
    .resume_two(resume_two_q),
    .stop_one(stop_one_q),
    .stop_two(stop_two_q),
    .rx_char(rx_char),
    .stop_hit(stop_hit),
    .resume_hit(resume_hit),
    .spec_hit(spec_hit)
  );

  assign stop_ev = rx_valid & rx_fc_on & stop_hit;
  assign resume_ev = rx_valid & rx_fc_on & resume_hit;
  assign spec_ev = rx_valid & spec_on & spec_hit;

  assign upper_lvl = upper_thr_q[LEVEL_W-1:0];
  assign lower_lvl = lower_thr_q[LEVEL_W-1:0];
  assign above_upper = rx_fifo_fill_level > upper_lvl;
  assign at_upper = rx_fifo_fill_level >= upper_lvl;
  assign below_lower = rx_fifo_fill_level < lower_lvl;

  assign tx_stop_char = (tx_sel == `SEL_PAIR_TWO) ? stop_two_q
                                                  : stop_one_q;
  assign tx_resume_char = (tx_sel == `SEL_PAIR_TWO) ? resume_two_q
                                                    : resume_one_q;

  assign status_rd = access_rd & (idx == `IDX_ADV_STATUS);
  assign irq_sts_wr = access_wr & (idx == `IDX_IRQ_STATUS);

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (idx)
      `IDX_DIV_LOW: rd_word[7:0] = div_low_q;
      `IDX_DIV_HIGH: rd_word[7:0] = div_high_q;
      `IDX_FEATURE: rd_word[7:0] = feature_q;
      `IDX_RESUME_ONE: rd_word[7:0] = resume_one_q;
      `IDX_RESUME_TWO: rd_word[7:0] = resume_two_q;
      `IDX_STOP_ONE: rd_word[7:0] = stop_one_q;
      `IDX_STOP_TWO: rd_word[7:0] = stop_two_q;
      `IDX_ADV_STATUS: begin
        rd_word[`ST_HALTED] = halted_q;
        rd_word[`ST_STOP_SENT] = stop_sent_q;
        rd_word[`ST_FLOW_DET] = flow_det_q;
        rd_word[`ST_SPEC_DET] = spec_det_q;
      end
      `IDX_LOWER_THR: rd_word[7:0] = lower_thr_q;
      `IDX_UPPER_THR: rd_word[7:0] = upper_thr_q;
      `IDX_IRQ_STATUS: rd_word[1:0] = irq_sts_q;
      `IDX_IRQ_MASK: rd_word[1:0] = irq_mask_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // One wait-free access phase: answer prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= ~rd_hit;
        prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
      end else begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_low_q <= `RST_BYTE;
      div_high_q <= `RST_BYTE;
    end else if (ce && access_wr) begin
      if (idx == `IDX_DIV_LOW) begin
        div_low_q <= pwdata[7:0];
      end
      if (idx == `IDX_DIV_HIGH) begin
        div_high_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feature_q <= `RST_BYTE;
      resume_one_q <= `RST_BYTE;
      resume_two_q <= `RST_BYTE;
      stop_one_q <= `RST_BYTE;
      stop_two_q <= `RST_BYTE;
      lower_thr_q <= `RST_BYTE;
      upper_thr_q <= `RST_BYTE;
      irq_mask_q <= 2'h0;
    end else if (ce && access_wr) begin
      unique case (idx)
        `IDX_FEATURE: feature_q <= pwdata[7:0];
        `IDX_RESUME_ONE: resume_one_q <= pwdata[7:0];
        `IDX_RESUME_TWO: resume_two_q <= pwdata[7:0];
        `IDX_STOP_ONE: stop_one_q <= pwdata[7:0];
        `IDX_STOP_TWO: stop_two_q <= pwdata[7:0];
        `IDX_LOWER_THR: lower_thr_q <= pwdata[7:0];
        `IDX_UPPER_THR: upper_thr_q <= pwdata[7:0];
        `IDX_IRQ_MASK: irq_mask_q <= pwdata[1:0];
        default: irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  // Bit-period tick; divisor zero stops the tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor <= `RST_DIVISOR;
      tick_cnt_q <= 16'h0000;
      bit_tick_q <= 1'b0;
    end else if (ce) begin
      divisor <= {div_high_q, div_low_q};
      if ({div_high_q, div_low_q} == 16'h0000) begin
        tick_cnt_q <= 16'h0000;
        bit_tick_q <= 1'b0;
      end else if (tick_cnt_q >= {div_high_q, div_low_q} - 16'h0001) begin
        tick_cnt_q <= 16'h0000;
        bit_tick_q <= 1'b1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 16'h0001;
        bit_tick_q <= 1'b0;
      end
    end
  end
  assign bit_tick = bit_tick_q;

  // Halt waits for the character on the wire to finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_pend_q <= 1'b0;
      halted_q <= 1'b0;
    end else if (ce) begin
      if (!rx_fc_on || resume_ev) begin
        halt_pend_q <= 1'b0;
        halted_q <= 1'b0;
      end else if (stop_ev || halt_pend_q) begin
        halt_pend_q <= tx_busy;
        halted_q <= halted_q | ~tx_busy;
      end
    end
  end

  // Detect flags clear on read; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_det_q <= 1'b0;
      spec_det_q <= 1'b0;
    end else if (ce) begin
      if (stop_ev || resume_ev) begin
        flow_det_q <= 1'b1;
      end else if (status_rd) begin
        flow_det_q <= 1'b0;
      end
      if (spec_ev) begin
        spec_det_q <= 1'b1;
      end else if (status_rd) begin
        spec_det_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_q <= 2'h0;
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_sts_q[`IRQ_FLOW] <= (stop_ev | resume_ev) |
        (irq_sts_q[`IRQ_FLOW] &
         ~(irq_sts_wr & pwdata[`IRQ_FLOW]));
      irq_sts_q[`IRQ_SPEC] <= spec_ev |
        (irq_sts_q[`IRQ_SPEC] &
         ~(irq_sts_wr & pwdata[`IRQ_SPEC]));
      irq_q <= |(irq_sts_q & irq_mask_q);
    end
  end
  assign irq = irq_q;

  // In-band insertion; one request held until the transmitter takes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ins_state_q <= INS_IDLE;
      stop_sent_q <= 1'b0;
      ins_valid_q <= 1'b0;
      ins_char_q <= `RST_BYTE;
    end else if (ce) begin
      unique case (ins_state_q)
        INS_IDLE: begin
          if (!tx_fc_on) begin
            stop_sent_q <= 1'b0;
          end else if (!stop_sent_q && above_upper) begin
            ins_state_q <= INS_STOP;
            ins_valid_q <= 1'b1;
            ins_char_q <= tx_stop_char;
          end else if (stop_sent_q && below_lower) begin
            ins_state_q <= INS_RESUME;
            ins_valid_q <= 1'b1;
            ins_char_q <= tx_resume_char;
          end
        end
        INS_STOP: begin
          if (ins_ready) begin
            ins_state_q <= INS_IDLE;
            ins_valid_q <= 1'b0;
            stop_sent_q <= 1'b1;
          end
        end
        INS_RESUME: begin
          if (ins_ready) begin
            ins_state_q <= INS_IDLE;
            ins_valid_q <= 1'b0;
            stop_sent_q <= 1'b0;
          end
        end
      endcase
    end
  end
  assign ins_valid = ins_valid_q;
  assign ins_char = ins_char_q;

  // Pin input, two stages before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_n_s1_q <= 1'b0;
      cts_n_s2_q <= 1'b0;
    end else if (ce) begin
      cts_n_s1_q <= cts_n;
      cts_n_s2_q <= cts_n_s1_q;
    end
  end

  // Gate only starts; a character already started runs to its end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_allow_q <= 1'b1;
    end else if (ce) begin
      tx_allow_q <= ~halted_q & ~halt_pend_q & ~stop_ev &
                    ~(auto_cts & cts_n_s2_q);
    end
  end
  assign tx_allow = tx_allow_q;

  // Hysteresis between the two levels avoids chatter on rts_n
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_hold_q <= 1'b0;
      rts_n_q <= 1'b0;
    end else if (ce) begin
      if (!auto_rts) begin
        rts_hold_q <= 1'b0;
        rts_n_q <= 1'b0;
      end else if (at_upper) begin
        rts_hold_q <= 1'b1;
        rts_n_q <= 1'b1;
      end else if (below_lower) begin
        rts_hold_q <= 1'b0;
        rts_n_q <= 1'b0;
      end else begin
        rts_n_q <= rts_hold_q;
      end
    end
  end
  assign rts_n = rts_n_q;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule

// ===== sim/fc_chk_asserts.sv
`timescale 1ns/10ps
`include "uart_fc_cfg.svh"
module fc_chk #(
  parameter int ADDR_W = 8,
  parameter int LEVEL_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [LEVEL_W-1:0] rx_fifo_fill_level,
  input wire logic ins_ready,
  input wire logic ins_valid,
  input wire uart_fc_pkg::char_type ins_char,
  input wire logic tx_allow,
  input wire logic [15:0] divisor,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic irq
);
  logic [7:0] feat_q;
  logic [7:0] up_q;
  logic [7:0] lo_q;
  wire logic wr_ok = psel && penable && pready && pwrite && ce;
  wire logic arts = feat_q[`ENH_BIT] && feat_q[`ARTS_BIT];
  // Shadow config, committed on the same edge as the design's registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feat_q <= 8'h00;
      up_q <= 8'h00;
      lo_q <= 8'h00;
    end else if (wr_ok && paddr[7:2] == `IDX_FEATURE) begin
      feat_q <= pwdata[7:0];
    end else if (wr_ok && paddr[7:2] == `IDX_UPPER_THR) begin
      up_q <= pwdata[7:0];
    end else if (wr_ok && paddr[7:2] == `IDX_LOWER_THR) begin
      lo_q <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_answer; psel && !penable && ce |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no access after setup");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  // Divisor output is registered once more after the byte registers
  property p_div_lo;
    wr_ok && paddr[7:2] == `IDX_DIV_LOW |->
      ##2 divisor[7:0] == $past(pwdata[7:0], 2);
  endproperty
  a_div_lo: assert property (p_div_lo) else $error("low divisor");
  property p_div_hi;
    wr_ok && paddr[7:2] == `IDX_DIV_HIGH |->
      ##2 divisor[15:8] == $past(pwdata[7:0], 2);
  endproperty
  a_div_hi: assert property (p_div_hi) else $error("high divisor");
  property p_rts_set; ce && arts && rx_fifo_fill_level >= up_q |=> rts_n;
  endproperty
  a_rts_set: assert property (p_rts_set) else $error("rts not raised");
  property p_rts_clr; ce && arts && rx_fifo_fill_level < lo_q |=> !rts_n;
  endproperty
  a_rts_clr: assert property (p_rts_clr) else $error("rts not freed");
  property p_cts;
    (ce && feat_q[`ENH_BIT] && feat_q[`ACTS_BIT] && cts_n)[*3] |=> !tx_allow;
  endproperty
  a_cts: assert property (p_cts) else $error("sending while paused");
  property p_ins_hold;
    ins_valid && !ins_ready && ce |=> ins_valid && $stable(ins_char);
  endproperty
  a_ins_hold: assert property (p_ins_hold) else $error("insert dropped");
  property p_legacy;
    !feat_q[`ENH_BIT] ##1 !feat_q[`ENH_BIT] |-> !rts_n && !ins_valid;
  endproperty
  a_legacy: assert property (p_legacy) else $error("extended in legacy");
  c_ins: cover property (ins_valid && ins_ready);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
endmodule
bind flow_ctrl_core fc_chk #(.ADDR_W(ADDR_W), .LEVEL_W(LEVEL_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .rx_fifo_fill_level(rx_fifo_fill_level), .ins_ready(ins_ready),
  .ins_valid(ins_valid), .ins_char(ins_char), .tx_allow(tx_allow),
  .divisor(divisor), .cts_n(cts_n), .rts_n(rts_n), .irq(irq));

// ===== sim/remote_line.sv
`timescale 1ns/10ps
module remote_line (
  input wire logic pclk,
  output logic rx_valid,
  output uart_fc_pkg::char_type rx_char,
  output logic tx_busy,
  output logic ins_ready,
  output logic cts_n
);
  import uart_fc_pkg::*;
  logic stall_q = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
    tx_busy = 1'b0;
    cts_n = 1'b0;
  end
  assign ins_ready = !stall_q;
  task automatic send(input char_type c);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_char <= c;
    @(posedge pclk);
    rx_valid <= 1'b0;
    // Idle bus shows no stale character
    rx_char <= ~c;
  endtask
endmodule

// ===== sim/uart_flow_ctrl_divisor_tb.sv
`timescale 1ns/10ps
`include "uart_fc_cfg.svh"
module uart_flow_ctrl_divisor_tb;
  import uart_fc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] level = 8'h00;
  logic ce = 1'b1;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, rx_valid, tx_busy, ins_ready, ins_valid;
  logic tx_allow, bit_tick, cts_n, rts_n, irq;
  char_type rx_char, ins_char;
  logic [15:0] divisor;
  int errors = 0;
  int n_tests = 0;
  always #50 pclk = ~pclk;
  flow_ctrl_core u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_char(rx_char), .rx_fifo_fill_level(level),
    .tx_busy(tx_busy), .ins_ready(ins_ready), .ins_valid(ins_valid),
    .ins_char(ins_char), .tx_allow(tx_allow), .divisor(divisor),
    .bit_tick(bit_tick), .cts_n(cts_n), .rts_n(rts_n), .irq(irq));
  remote_line u_far (.pclk(pclk), .rx_valid(rx_valid), .rx_char(rx_char),
    .tx_busy(tx_busy), .ins_ready(ins_ready), .cts_n(cts_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [5:0] idx,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the commit edge land before anyone looks
    @(posedge pclk);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d});
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, {24'h0, exp});
  endtask
  task automatic wait_ins(input logic v);
    int n;
    n = 0;
    while (ins_valid !== v && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (ins_valid !== v) chk({31'h0, ins_valid}, {31'h0, v});
  endtask
  task automatic t_regs;
    int n;
    rdc(`IDX_DIV_LOW, 8'h00);
    rdc(`IDX_DIV_HIGH, 8'h00);
    rdc(`IDX_FEATURE, 8'h00);
    wr(`IDX_DIV_LOW, 8'h05);
    wr(`IDX_DIV_HIGH, 8'ha5);
    rdc(`IDX_DIV_HIGH, 8'ha5);
    // Divisor output trails the byte registers by one cycle
    chk({16'h0, divisor}, 32'ha505);
    apb(1'b1, 6'h3f, 32'hffffffff);
    chk({31'h0, err}, 32'h1);
    wr(`IDX_DIV_HIGH, 8'h00);
    n = 0;
    while (bit_tick !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (bit_tick !== 1'b1 && n < 40);
    chk(32'(n), 32'h5);
    // Three frozen cycles stretch this tick period from five to eight
    ce <= 1'b0;
    cyc(3);
    ce <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (bit_tick !== 1'b1 && n < 40);
    chk(32'(n), 32'h5);
    $display("t_regs end");
  endtask
  task automatic t_rx;
    logic [23:0] t [3] = '{24'h131412, 24'h141311, 24'h551411};
    wr(`IDX_RESUME_ONE, 8'h11);
    wr(`IDX_RESUME_TWO, 8'h12);
    wr(`IDX_STOP_ONE, 8'h13);
    wr(`IDX_STOP_TWO, 8'h14);
    for (int i = 0; i < 3; i++) begin
      wr(`IDX_FEATURE, 8'h38 | 8'(i + 1));
      u_far.send(t[i][23:16]);
      cyc(3);
      chk({31'h0, tx_allow}, 32'h1);
      // First pass stops while a character is still on the wire
      u_far.tx_busy <= (i == 0);
      u_far.send(t[i][15:8]);
      cyc(3);
      chk({31'h0, tx_allow}, 32'h0);
      u_far.tx_busy <= 1'b0;
      rdc(`IDX_ADV_STATUS, 8'h0d);
      u_far.send(t[i][7:0]);
      cyc(3);
      chk({31'h0, tx_allow}, 32'h1);
      rdc(`IDX_ADV_STATUS, 8'h04);
    end
    wr(`IDX_FEATURE, 8'h22);
    u_far.send(8'h13);
    cyc(3);
    chk({31'h0, tx_allow}, 32'h1);
    rdc(`IDX_ADV_STATUS, 8'h00);
    $display("t_rx end");
  endtask
  task automatic t_irq;
    rdc(`IDX_IRQ_STATUS, 8'h03);
    chk({31'h0, irq}, 32'h0);
    wr(`IDX_IRQ_MASK, 8'h01);
    cyc(3);
    chk({31'h0, irq}, 32'h1);
    wr(`IDX_IRQ_STATUS, 8'h01);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    rdc(`IDX_IRQ_STATUS, 8'h02);
    wr(`IDX_IRQ_MASK, 8'h03);
    cyc(3);
    chk({31'h0, irq}, 32'h1);
    wr(`IDX_IRQ_STATUS, 8'h02);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    $display("t_irq end");
  endtask
  task automatic t_ins;
    logic [15:0] p [2] = '{16'h1412, 16'h1311};
    wr(`IDX_UPPER_THR, 8'h08);
    wr(`IDX_LOWER_THR, 8'h02);
    for (int i = 0; i < 2; i++) begin
      u_far.stall_q <= 1'b1;
      wr(`IDX_FEATURE, 8'hf0 | 8'((i + 1) << 2));
      level <= 8'h09;
      wait_ins(1'b1);
      chk({24'h0, ins_char}, {24'h0, p[i][15:8]});
      chk({31'h0, rts_n}, 32'h1);
      cyc(3);
      chk({31'h0, ins_valid}, 32'h1);
      u_far.stall_q <= 1'b0;
      wait_ins(1'b0);
      rdc(`IDX_ADV_STATUS, 8'h02);
      level <= 8'h05;
      cyc(3);
      chk({31'h0, rts_n}, 32'h1);
      level <= 8'h01;
      wait_ins(1'b1);
      chk({24'h0, ins_char}, {24'h0, p[i][7:0]});
      wait_ins(1'b0);
      chk({31'h0, rts_n}, 32'h0);
    end
    u_far.cts_n <= 1'b1;
    cyc(5);
    chk({31'h0, tx_allow}, 32'h0);
    u_far.cts_n <= 1'b0;
    cyc(5);
    chk({31'h0, tx_allow}, 32'h1);
    $display("t_ins end");
  endtask
  task automatic close_out;
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_rx;
    t_irq;
    t_ins;
    close_out;
  end
  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    close_out;
  end
endmodule
